//--- inc/web_guide_defs.svh
// constants of the web guide control block
`ifndef WEB_GUIDE_DEFS_SVH
`define WEB_GUIDE_DEFS_SVH
// register offsets (index of each 32-bit word, byte address = 4 * index)
`define REG_SETPOINT 4'h0
`define REG_MODE 4'h1
`define REG_BAND 4'h2
`define REG_RELAY 4'h3
`define REG_INPUT 4'h4
`define REG_STATUS 4'h5
`define REG_EDGE 4'h6
// setpoint in 0.01 mm units, limits +-5.00 mm
`define SP_MAX 16'sd500
`define SP_MIN -16'sd500
`define SP_STEP 16'sd1
// dead band in 0.01 mm units: 0.0..2.0 mm, step 0.1 mm, default 0.1 mm
`define BAND_MAX 8'd200
`define BAND_STEP 8'd10
`define BAND_RST 8'd10
// mode register field positions
`define MODE_SRC_AUTO 0
`define MODE_RETAIN 1
`define MODE_LEAVE_CTR 2
// relay and input field reset values
`define RELAY_RST 8'h10
`define INPUT_RST 16'h5431
// pulse step repeat time in ms
`define STEP_MS 100
`define CLK_KHZ 10000
`endif

//--- inc/web_guide_pkg.sv
// types of the web guide control block
package web_guide_pkg;
  typedef enum logic [3:0] {
    RLY_MID, RLY_MAT, RLY_AUTO_MAT, RLY_AUTO_MISS, RLY_AUTO, RLY_CENTRE,
    RLY_OFF
  } relay_sel_e;
  typedef enum logic [3:0] {
    IN_OFF, IN_TOGGLE, IN_LEVEL, IN_CENTRE, IN_DEC, IN_INC, IN_HOLD,
    IN_CLEAR
  } input_sel_e;
  typedef enum logic [1:0] {DRV_IDLE, DRV_GUIDE, DRV_CENTRE, DRV_HOLD}
    drive_state_e;
endpackage

//--- src/input_sync.sv
// two-flop synchroniser with rising-edge detect for the digital inputs
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sync_s;
  sync_s s_q, s_d;

  initial begin
    if (WIDTH < 1) $error("input_sync: WIDTH must be positive");
  end

  // first stage only feeds the second stage
  always_comb begin
    s_d = s_q;
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.sync;
  assign o_rise = s_q.sync & ~s_q.prev;
endmodule

//--- src/web_guide_io_control.sv
// web guide setpoint, dead band, relay and digital input control
`timescale 1ns/100ps
`include "web_guide_defs.svh"

// How it works
// - setpoint offset held -5.00..+5.00 mm in 0.01 mm steps, default 0.
// - manual source uses stored offset; auto captures edge on entering auto.
// - after reboot setpoint is zero whether or not retention is on.
// - no correction inside +-dead band; correct when deviation exceeds it.
// - mid-sensor relay condition: on while edge sits at sensor middle.
// - material-present relay condition: on while an edge is detected.
// - combined condition: on while material present and guiding automatic.
// - missing condition: on while automatic and no material detected.
// - automatic condition: on whenever guiding is automatic.
// - centring condition: on once drive rests after a centring move.
// - toggle input swaps automatic and manual on each rising edge.
// - level input: high means automatic, low means manual.
// - centring input edge starts a move to the centre, in manual only.
// - decrement input: move left in manual, lower setpoint in automatic.
// - increment input: move right in manual, raise setpoint in automatic.
// - hold input high locks the drive, except during a centring move with leave-centre on.
// - auto guides unless held; inactive goes centre or stops per setting.
// - clear input rising edge sets the setpoint to zero.
// - disabled input ignores all levels and edges.
// - leaving automatic stops guiding, then holds or centres per setting.
module web_guide_io_control #(
  parameter int STEP_CYCLES = `STEP_MS * `CLK_KHZ
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_din,
  input wire logic signed [15:0] i_edge_pos,
  input wire logic i_edge_valid,
  input wire logic i_edge_mid,
  input wire logic i_drive_at_centre,
  input wire logic i_drive_moving,
  output logic [31:0] o_rdata,
  output logic [1:0] o_relay,
  output logic o_steer_left,
  output logic o_steer_right,
  output logic o_jog_left,
  output logic o_jog_right,
  output logic o_centre_req,
  output logic o_drive_lock,
  output logic o_auto_active
);
  import web_guide_pkg::*;

  // =====================================================================
  // state
  typedef struct packed {
    logic signed [15:0] sp;
    logic signed [15:0] sp_saved;
    logic retained;
    logic src_auto;
    logic retain;
    logic leave_ctr;
    logic [7:0] band;
    logic [7:0] relay_cfg;
    logic [15:0] input_cfg;
    logic auto;
    logic centring;
    logic centre_done;
    drive_state_e drv;
    logic [31:0] step_cnt;
    logic [31:0] rdata;
    logic [1:0] relay;
    logic st_l;
    logic st_r;
    logic jog_l;
    logic jog_r;
    logic ctr_req;
    logic lock;
  } state_s;
  state_s s_q, s_d;

  logic [3:0] lvl;
  logic [3:0] rise;

  initial begin
    if (STEP_CYCLES < 1) $error("STEP_CYCLES must be at least one");
  end

  // =====================================================================
  // input conditioning
  // sync before use
  input_sync #(.WIDTH(4)) u_sync (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_async(i_din),
    .o_level(lvl),
    .o_rise(rise)
  );

  // window clamp
  // clamp a signed setpoint into the legal window
  function automatic logic signed [15:0] clamp_sp(
    input logic signed [16:0] v);
    if (v > 17'(`SP_MAX)) clamp_sp = `SP_MAX;
    else if (v < 17'(`SP_MIN)) clamp_sp = `SP_MIN;
    else clamp_sp = v[15:0];
  endfunction

  // which inputs carry a given function (disabled ones never match)
  function automatic logic [3:0] has_fn(input logic [15:0] cfg,
                                        input input_sel_e fn);
    has_fn = '0;
    for (int k = 0; k < 4; k++) begin
      has_fn[k] = (cfg[k*4 +: 4] == 4'(fn));
    end
  endfunction

  // relay condition evaluation
  function automatic logic relay_on(input logic [3:0] sel,
    input logic mid, input logic mat, input logic aut, input logic cdone);
    case (sel)
      4'(RLY_MID): relay_on = mid;         // mid sensor
      4'(RLY_MAT): relay_on = mat;         // material present
      4'(RLY_AUTO_MAT): relay_on = mat & aut;   // combined
      4'(RLY_AUTO_MISS): relay_on = ~mat & aut; // missing
      4'(RLY_AUTO): relay_on = aut;        // auto state
      4'(RLY_CENTRE): relay_on = cdone;    // centring rest
      default: relay_on = 1'b0;            // disabled off
    endcase
  endfunction

  // =====================================================================
  // next state
  always_comb begin
    logic [3:0] f_tog, f_lvl, f_ctr, f_dec, f_inc, f_hold, f_clr;
    logic hold, step_tick, want_auto, dec_on, inc_on;
    logic signed [16:0] dev, band_s;
    f_tog = '0;
    f_lvl = '0;
    f_ctr = '0;
    f_dec = '0;
    f_inc = '0;
    f_hold = '0;
    f_clr = '0;
    hold = 1'b0;
    step_tick = 1'b0;
    want_auto = 1'b0;
    dec_on = 1'b0;
    inc_on = 1'b0;
    dev = '0;
    band_s = '0;
    s_d = s_q;
    f_tog = has_fn(s_q.input_cfg, IN_TOGGLE);
    f_lvl = has_fn(s_q.input_cfg, IN_LEVEL);
    f_ctr = has_fn(s_q.input_cfg, IN_CENTRE);
    f_dec = has_fn(s_q.input_cfg, IN_DEC);
    f_inc = has_fn(s_q.input_cfg, IN_INC);
    f_hold = has_fn(s_q.input_cfg, IN_HOLD);
    f_clr = has_fn(s_q.input_cfg, IN_CLEAR);
    hold = |(f_hold & lvl);
    dec_on = |(f_dec & lvl);
    inc_on = |(f_inc & lvl);

    // register writes; software keeps source and retain exclusive
    if (i_wr) begin
      case (i_addr)
        `REG_SETPOINT: s_d.sp = clamp_sp(17'(signed'(i_wdata[15:0])));
        `REG_MODE: begin
          s_d.src_auto = i_wdata[`MODE_SRC_AUTO];
          s_d.retain = i_wdata[`MODE_RETAIN];
          s_d.leave_ctr = i_wdata[`MODE_LEAVE_CTR];
        end
        `REG_BAND: begin
          if (i_wdata[7:0] <= `BAND_MAX) s_d.band = i_wdata[7:0];
        end
        `REG_RELAY: s_d.relay_cfg = i_wdata[7:0];
        `REG_INPUT: s_d.input_cfg = i_wdata[15:0];
        default: ;
      endcase
    end

    // repeat tick for held step inputs
    if (s_q.step_cnt >= 32'(STEP_CYCLES - 1)) begin
      s_d.step_cnt = '0;
      step_tick = 1'b1;
    end else begin
      s_d.step_cnt = s_q.step_cnt + 32'd1;
    end

    want_auto = s_q.auto ^ (|(f_tog & rise));
    if (|f_lvl) want_auto = |(f_lvl & lvl);
    s_d.auto = want_auto;

    if (want_auto && !s_q.auto && s_q.src_auto && i_edge_valid) begin
      s_d.sp = clamp_sp(17'(i_edge_pos));
    end
    if (s_q.auto && step_tick) begin
      if (dec_on && !inc_on) begin
        s_d.sp = clamp_sp(17'(s_q.sp) - 17'(`SP_STEP));
      end else if (inc_on && !dec_on) begin
        s_d.sp = clamp_sp(17'(s_q.sp) + 17'(`SP_STEP));
      end
    end
    if (|(f_clr & rise)) s_d.sp = '0;
    s_d.sp_saved = s_d.sp;
    s_d.retained = s_q.retain;

    if (|(f_ctr & rise)) begin
      s_d.centring = 1'b1;
      s_d.centre_done = 1'b0;
    end
    if (s_q.auto && !want_auto && s_q.leave_ctr) begin
      s_d.centring = 1'b1;
      s_d.centre_done = 1'b0;
    end
    if (want_auto) s_d.centring = 1'b0;
    if (s_q.centring && i_drive_at_centre && !i_drive_moving) begin
      s_d.centring = 1'b0;
      s_d.centre_done = 1'b1;
    end else if (i_drive_moving) begin
      s_d.centre_done = 1'b0;
    end

    if (s_q.auto) begin
      s_d.drv = hold ? DRV_HOLD : DRV_GUIDE;
    end else if (s_q.leave_ctr && s_q.centring) begin
      s_d.drv = DRV_CENTRE;
    end else if (s_q.centring && !hold) begin
      s_d.drv = DRV_CENTRE;
    end else if (hold) begin
      s_d.drv = DRV_HOLD;
    end else begin
      s_d.drv = DRV_IDLE;
    end

    dev = 17'(i_edge_pos) - 17'(s_q.sp);
    band_s = 17'(s_q.band);
    s_d.st_l = 1'b0;
    s_d.st_r = 1'b0;
    if (s_q.drv == DRV_GUIDE && i_edge_valid) begin
      s_d.st_l = dev > band_s;
      s_d.st_r = dev < -band_s;
    end
    s_d.jog_l = (s_q.drv == DRV_IDLE) && !s_q.auto && dec_on && !inc_on;
    s_d.jog_r = (s_q.drv == DRV_IDLE) && !s_q.auto && inc_on && !dec_on;
    s_d.ctr_req = s_q.drv == DRV_CENTRE;
    s_d.lock = hold && !(s_q.drv == DRV_CENTRE);

    for (int r = 0; r < 2; r++) begin
      s_d.relay[r] = relay_on(s_q.relay_cfg[r*4 +: 4], i_edge_mid,
                              i_edge_valid, s_q.auto, s_q.centre_done);
    end

    // read data one cycle after the strobe, zero otherwise
    s_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        `REG_SETPOINT: s_d.rdata = {{16{s_q.sp[15]}}, s_q.sp};
        `REG_MODE: s_d.rdata = {29'd0, s_q.leave_ctr, s_q.retain,
                                s_q.src_auto};
        `REG_BAND: s_d.rdata = {24'd0, s_q.band};
        `REG_RELAY: s_d.rdata = {24'd0, s_q.relay_cfg};
        `REG_INPUT: s_d.rdata = {16'd0, s_q.input_cfg};
        `REG_STATUS: s_d.rdata = {20'd0, lvl, s_q.relay, s_q.drv,
                                  s_q.centre_done, s_q.centring,
                                  s_q.lock, s_q.auto};
        `REG_EDGE: s_d.rdata = {{16{i_edge_pos[15]}}, i_edge_pos};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // =====================================================================
  // registers; reset clears the setpoint, its saved copy and the retain
  // flag alike, so every reset starts the setpoint at zero
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.band <= `BAND_RST;
      s_q.relay_cfg <= `RELAY_RST;
      s_q.input_cfg <= `INPUT_RST;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_relay = s_q.relay;
  assign o_steer_left = s_q.st_l;
  assign o_steer_right = s_q.st_r;
  assign o_jog_left = s_q.jog_l;
  assign o_jog_right = s_q.jog_r;
  assign o_centre_req = s_q.ctr_req;
  assign o_drive_lock = s_q.lock;
  assign o_auto_active = s_q.auto;

  // =====================================================================
  // checks
  property p_clear;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_ce && |(has_fn(s_q.input_cfg, IN_CLEAR) & rise) && !i_wr)
      |=> s_q.sp == 16'sd0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed");

  property p_band;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_ce && s_q.drv == DRV_GUIDE && i_edge_valid &&
     17'(i_edge_pos) - 17'(s_q.sp) <= $signed(17'(s_q.band)) &&
     17'(s_q.sp) - 17'(i_edge_pos) <= $signed(17'(s_q.band)))
      |=> !o_steer_left && !o_steer_right;
  endproperty
  a_band: assert property (p_band) else $error("steer in band");

  property p_sp_range;
    @(posedge i_mclk) disable iff (!i_reset_n)
    s_q.sp <= `SP_MAX && s_q.sp >= `SP_MIN;
  endproperty
  a_sp_range: assert property (p_sp_range) else $error("sp range");

  property p_auto_relay;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_ce && s_q.relay_cfg[3:0] == 4'(RLY_AUTO))
      |=> o_relay[0] == $past(s_q.auto);
  endproperty
  a_auto_relay: assert property (p_auto_relay)
    else $error("relay auto");

  property p_off_relay;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_ce && s_q.relay_cfg[7:4] == 4'(RLY_OFF)) |=> !o_relay[1];
  endproperty
  a_off_relay: assert property (p_off_relay) else $error("relay off");

  property p_hold;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_ce && s_q.auto && |(has_fn(s_q.input_cfg, IN_HOLD) & lvl))
      |=> s_q.drv == DRV_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("hold missed");
endmodule

//--- test/plant_model.sv
// plant equipment model: drives the digital inputs, watches the relays
`timescale 1ns/100ps
module plant_model #(
  parameter int PULSE_CYC = 12
) (
  input wire logic i_mclk,
  input wire logic [1:0] i_relay,
  output logic [3:0] o_din
);
  logic [1:0] relay_q;
  initial o_din = 4'h0;
  // relay contacts as the plant sees them, one clock late
  always_ff @(posedge i_mclk) begin
    relay_q <= i_relay;
  end
  // steady level on one input, changed right after an edge
  task automatic level(input int n, input logic v);
    @(posedge i_mclk);
    o_din[n] <= v;
  endtask
  // bounded pulse length
  // pulse width stands for the 100..500 ms window, scaled down to keep
  // the run short; the low gap after it keeps edges apart
  task automatic pulse(input int n);
    level(n, 1'b1);
    repeat (PULSE_CYC) @(posedge i_mclk);
    o_din[n] <= 1'b0;
    repeat (PULSE_CYC) @(posedge i_mclk);
  endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the web guide io control block
`timescale 1ns/100ps
`include "web_guide_defs.svh"
module testbench;
  logic mclk = 1'b0;
  logic reset_n, wr, rd, edge_valid, edge_mid, at_centre, moving, ce;
  logic [3:0] addr, din;
  logic [31:0] wdata, rdata, r;
  logic signed [15:0] edge_pos;
  logic [1:0] relay;
  logic steer_l, steer_r, jog_l, jog_r, centre_req, lock, auto_on;
  int error_cnt = 0;
  int tests_run = 0;
  int pos_t[4] = '{133, 134, 113, 112};
  logic [1:0] st_t[4] = '{2'h0, 2'h2, 2'h0, 2'h1};

  // ==========
  // design and plant
  web_guide_io_control #(.STEP_CYCLES(4)) uut (
    .i_mclk(mclk),
    .i_reset_n(reset_n),
    .i_ce(ce),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .i_din(din),
    .i_edge_pos(edge_pos),
    .i_edge_valid(edge_valid),
    .i_edge_mid(edge_mid),
    .i_drive_at_centre(at_centre),
    .i_drive_moving(moving),
    .o_rdata(rdata),
    .o_relay(relay),
    .o_steer_left(steer_l),
    .o_steer_right(steer_r),
    .o_jog_left(jog_l),
    .o_jog_right(jog_r),
    .o_centre_req(centre_req),
    .o_drive_lock(lock),
    .o_auto_active(auto_on)
  );
  plant_model #(.PULSE_CYC(12)) pm (
    .i_mclk(mclk), .i_relay(relay), .o_din(din)
  );
  // 100 ns clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  // ==========
  // bus and check tasks
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data only stand in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    r = rdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_reg(input string s, input logic [3:0] a,
                         input logic [15:0] e, input logic [15:0] m);
    rd_reg(a);
    chk(s, {16'h0000, e & m}, {16'h0000, r[15:0] & m});
  endtask
  // waits n edges, then samples mid-cycle where outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic do_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog: the tests need under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    tally_and_finish;
  end

  // ==========
  // test sequence
  initial begin
    int a, v, m, s, e;
    reset_n = 1'b0;
    ce = 1'b1;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    edge_pos = 16'sh0000;
    edge_valid = 1'b0;
    edge_mid = 1'b0;
    at_centre = 1'b0;
    moving = 1'b0;
    do_reset;
    chk_reg("band", `REG_BAND, 16'h000a, 16'h00ff);
    chk_reg("relay cfg", `REG_RELAY, 16'h0010, 16'h00ff);
    chk_reg("input cfg", `REG_INPUT, 16'h5431, 16'hffff);
    chk_reg("setpoint", `REG_SETPOINT, 16'h0000, 16'hffff);
    wr_reg(`REG_BAND, 32'h0000_00d2);
    chk_reg("band", `REG_BAND, 16'h000a, 16'h00ff);
    // a frozen block must drop a legal write
    @(posedge mclk);
    ce <= 1'b0;
    wr_reg(`REG_BAND, 32'h0000_0014);
    ce <= 1'b1;
    chk_reg("band", `REG_BAND, 16'h000a, 16'h00ff);
    wr_reg(`REG_BAND, 32'h0000_0014);
    chk_reg("band", `REG_BAND, 16'h0014, 16'h00ff);
    wr_reg(`REG_BAND, 32'h0000_000a);
    wr_reg(`REG_SETPOINT, 32'h0000_0258);
    chk_reg("setpoint", `REG_SETPOINT, 16'h01f4, 16'hffff);
    wr_reg(`REG_SETPOINT, 32'hffff_fda8);
    chk_reg("setpoint", `REG_SETPOINT, 16'hfe0c, 16'hffff);
    wr_reg(`REG_SETPOINT, 32'hffff_ffff);
    chk_reg("setpoint", `REG_SETPOINT, 16'hffff, 16'hffff);
    $display("done registers");
    pm.pulse(0);
    chk("auto", 32'h1, 32'(auto_on));
    pm.pulse(0);
    chk("auto", 32'h0, 32'(auto_on));
    pm.level(2, 1'b1);
    cyc(6);
    chk("jog left", 32'h1, 32'(jog_l));
    pm.level(2, 1'b0);
    pm.level(3, 1'b1);
    cyc(6);
    chk("jog right", 32'h1, 32'(jog_r));
    pm.level(3, 1'b0);
    $display("done default inputs");
    wr_reg(`REG_RELAY, 32'h0000_0065);
    pm.pulse(1);
    chk("centre req", 32'h1, 32'(centre_req));
    chk("relay", 32'h0, 32'(relay));
    @(posedge mclk);
    moving <= 1'b1;
    repeat (4) @(posedge mclk);
    moving <= 1'b0;
    at_centre <= 1'b1;
    cyc(4);
    chk("relay", 32'h1, 32'(relay));
    $display("done centring");
    wr_reg(`REG_SETPOINT, 32'h0000_0000);
    pm.pulse(0);
    pm.pulse(3);
    rd_reg(`REG_SETPOINT);
    chk("sp up", 32'h1, 32'($signed(r[15:0]) > 0));
    pm.pulse(2);
    pm.pulse(2);
    rd_reg(`REG_SETPOINT);
    chk("sp down", 32'h1, 32'($signed(r[15:0]) < 0));
    pm.pulse(0);
    wr_reg(`REG_INPUT, 32'h0000_7431);
    pm.pulse(3);
    chk_reg("setpoint", `REG_SETPOINT, 16'h0000, 16'hffff);
    wr_reg(`REG_INPUT, 32'h0000_7430);
    pm.pulse(0);
    chk("auto", 32'h0, 32'(auto_on));
    $display("done setpoint inputs");
    wr_reg(`REG_INPUT, 32'h0000_5632);
    pm.level(0, 1'b1);
    cyc(1);
    chk("auto", 32'h0, 32'(auto_on));
    cyc(4);
    chk("auto", 32'h1, 32'(auto_on));
    // every relay condition but centring rest against every input mix; relay two off
    for (int k = 0; k < 48; k++) begin
      s = k % 6;
      m = (k / 6) % 2;
      v = (k / 12) % 2;
      a = k / 24;
      pm.level(0, a[0]);
      edge_valid <= v[0];
      edge_mid <= m[0];
      wr_reg(`REG_RELAY, {24'h00_0000, 4'h6, (s == 5) ? 4'h6 : s[3:0]});
      cyc(6);
      chk("auto", 32'(a), 32'(auto_on));
      e = (s == 0) ? m : (s == 1) ? v : (s == 2) ? (v & a) :
          (s == 3) ? (a & (1 - v)) : (s == 4) ? a : 0;
      chk("relay", 32'(e), 32'(relay));
      chk("plant", 32'(e), 32'(pm.relay_q));
    end
    $display("done relays");
    pm.level(0, 1'b0);
    at_centre <= 1'b0;
    edge_pos <= 16'sh007b;
    wr_reg(`REG_MODE, 32'h0000_0001);
    pm.level(0, 1'b1);
    cyc(6);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      edge_pos <= 16'(pos_t[i]);
      cyc(4);
      chk("steer", 32'(st_t[i]), {30'h0, steer_l, steer_r});
    end
    pm.level(2, 1'b1);
    cyc(6);
    chk("lock", 32'h1, 32'(lock));
    chk("steer", 32'h0, {30'h0, steer_l, steer_r});
    pm.level(2, 1'b0);
    cyc(6);
    chk("steer", 32'h1, {30'h0, steer_l, steer_r});
    pm.level(2, 1'b1);
    pm.level(0, 1'b0);
    cyc(6);
    chk("lock", 32'h1, 32'(lock));
    chk("centre req", 32'h0, 32'(centre_req));
    pm.level(2, 1'b0);
    wr_reg(`REG_MODE, 32'h0000_0005);
    pm.level(0, 1'b1);
    cyc(6);
    pm.level(0, 1'b0);
    cyc(6);
    chk("centre req", 32'h1, 32'(centre_req));
    chk("steer", 32'h0, {30'h0, steer_l, steer_r});
    $display("done guiding");
    wr_reg(`REG_SETPOINT, 32'h0000_00c8);
    wr_reg(`REG_MODE, 32'h0000_0000);
    do_reset;
    chk_reg("setpoint", `REG_SETPOINT, 16'h0000, 16'hffff);
    $display("done reboot");
    tally_and_finish;
  end
endmodule
